// ### hw/coc_pkg.sv
// coc_pkg: constants and state type shared by the compare output channel files.
// assumes a 16-bit register view reached through a small indexed port.
package coc_pkg;

    localparam int DW = 16;

    // register indices
    localparam logic [2:0] REG_CTRL1 = 3'h0;
    localparam logic [2:0] REG_CTRL2 = 3'h1;
    localparam logic [2:0] REG_PRI   = 3'h2;
    localparam logic [2:0] REG_SEC   = 3'h3;
    localparam logic [2:0] REG_TMR   = 3'h4;

    // second control register fields
    localparam int C2_LATCH   = 15;
    localparam int C2_FLVL    = 14;
    localparam int C2_FTRI    = 13;
    localparam int C2_INV     = 12;
    localparam int C2_CASC    = 8;
    localparam int C2_TRIG    = 7;
    localparam int C2_TSTAT   = 6;
    localparam int C2_PTRI    = 5;
    localparam int C2_SEL_LSB = 0;
    localparam int SEL_W      = 5;
    localparam logic [15:0] CTRL2_RST   = 16'h000c;
    localparam logic [15:0] CTRL2_WMASK = 16'hf1ff;

    // first control register fields
    localparam int C1_MODE_LSB = 0;
    localparam int MODE_W      = 3;
    localparam int C1_FEN      = 3;
    localparam int C1_FFLAG    = 4;

    // source select codes with a fixed meaning
    localparam logic [4:0] SRC_NONE_LO = 5'h00;
    localparam logic [4:0] SRC_NONE_HI = 5'h1f;

    typedef enum logic [2:0] {
        MODE_OFF     = 3'b000,
        MODE_SS_HIGH = 3'b001,
        MODE_SS_LOW  = 3'b010,
        MODE_TOGGLE  = 3'b011,
        MODE_DBL_SS  = 3'b100,
        MODE_DBL_CON = 3'b101,
        MODE_EDGE    = 3'b110,
        MODE_CENTER  = 3'b111
    } coc_mode_t;

    typedef struct packed {
        logic [DW-1:0] ctrl2;
        coc_mode_t     mode;
        logic          fault_en;
        logic          fault_flag;
        logic          fault_act;
        logic [DW-1:0] pri;
        logic [DW-1:0] sec;
        logic [DW-1:0] timer;
        logic          pwm;
        logic          oc;
        logic          oe;
        logic          trig_out;
        logic          carry;
        logic [DW-1:0] rdata;
    } coc_state_t;

endpackage : coc_pkg

// ### hw/coc_source_mux.sv
// coc_source_mux: picks one sync/trigger event out of the on-chip sources, taking only this channel's bit of seq_i.
// assumes every source is a one-cycle event pulse synchronous to the core clock.
module coc_source_mux #(
    parameter int CH_IDX = 0
) (
    // selection
    input  wire logic [4:0] sel_i,
    // sources
    input  wire logic [3:0] oc_trig_i,
    input  wire logic [3:0] seq_i,
    input  wire logic [4:0] timer_i,
    input  wire logic [3:0] capture_i,
    input  wire logic [2:0] cmp_i,
    input  wire logic       adc_i,
    input  wire logic       charge_time_unit_i,
    input  wire logic [1:0] irq_i,
    // result
    output logic            evt_o
);
    logic [31:0] table_w;
    logic [3:0]  oc_own_w;

    // a channel never hears its own trigger-out, so a bad select cannot self-loop
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_own
            assign oc_own_w[g] = (g == CH_IDX) ? 1'b0 : oc_trig_i[g];
        end
    endgenerate

    assign table_w = {1'b0, irq_i[1], irq_i[0], charge_time_unit_i, adc_i, cmp_i[2:0],
                      4'h0, capture_i[3:0], timer_i[4:0],
                      seq_i[CH_IDX],
                      5'h00, oc_own_w[3:0],
                      1'b0};
    assign evt_o = table_w[sel_i];

endmodule : coc_source_mux

// ### hw/coc_channel.sv
// coc_channel: one output compare channel with its second control stage.
// assumes synchronous inputs, event pulses of one cycle, and a register port
// whose read data appear one cycle after the read strobe.
module coc_channel #(
    parameter int CH_IDX = 0
) (
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    // register port
    input  wire logic [2:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [15:0] reg_rdata_o,
    // fault and cascade
    input  wire logic        fault_i,
    input  wire logic        cascade_carry_i,
    // sync and trigger sources
    input  wire logic [3:0]  oc_trig_i,
    input  wire logic [3:0]  seq_i,
    input  wire logic [4:0]  timer_i,
    input  wire logic [3:0]  capture_i,
    input  wire logic [2:0]  cmp_i,
    input  wire logic        adc_i,
    input  wire logic        charge_time_unit_i,
    input  wire logic [1:0]  irq_i,
    // compare pin and events
    output logic             oc_o,
    output logic             oc_oe_o,
    output logic             trig_out_o,
    output logic             carry_o
);
    coc_pkg::coc_state_t q;
    coc_pkg::coc_state_t d;
    logic                src_evt_w;

    coc_source_mux #(
        .CH_IDX    (CH_IDX)
    ) u_mux (
        .sel_i     (q.ctrl2[coc_pkg::C2_SEL_LSB +: coc_pkg::SEL_W]),
        .oc_trig_i (oc_trig_i),
        .seq_i     (seq_i),
        .timer_i   (timer_i),
        .capture_i (capture_i),
        .cmp_i     (cmp_i),
        .adc_i     (adc_i),
        .charge_time_unit_i    (charge_time_unit_i),
        .irq_i     (irq_i),
        .evt_o     (src_evt_w)
    );

    always_comb
    begin
        logic running;
        logic trig_sel;
        logic tick;
        logic period_end;
        logic period_start;
        logic match_pri;
        logic match_sec;
        logic fault_hit;
        logic fault_free;
        running      = 1'b0;
        trig_sel     = 1'b0;
        tick         = 1'b0;
        period_end   = 1'b0;
        period_start = 1'b0;
        match_pri    = 1'b0;
        match_sec    = 1'b0;
        fault_hit    = 1'b0;
        fault_free   = 1'b0;

        d          = q;
        d.trig_out = 1'b0;
        d.carry    = 1'b0;
        d.rdata    = '0;

        running   = (q.mode != coc_pkg::MODE_OFF);
        trig_sel  = q.ctrl2[coc_pkg::C2_TRIG];
        // as the upper half of a pair the timer only steps on the lower half's wrap
        tick      = q.ctrl2[coc_pkg::C2_CASC] ? cascade_carry_i : 1'b1;
        match_pri = (q.timer == q.pri);
        match_sec = (q.timer == q.sec);
        period_end = running && tick && match_sec;

        // software writes
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                coc_pkg::REG_CTRL1:
                begin
                    d.mode     = coc_pkg::coc_mode_t'(reg_wdata_i[coc_pkg::C1_MODE_LSB +: coc_pkg::MODE_W]);
                    d.fault_en = reg_wdata_i[coc_pkg::C1_FEN];
                    if (!reg_wdata_i[coc_pkg::C1_FFLAG])
                        d.fault_flag = 1'b0;
                    d.pwm = (coc_pkg::coc_mode_t'(reg_wdata_i[coc_pkg::C1_MODE_LSB +: coc_pkg::MODE_W])
                             == coc_pkg::MODE_SS_LOW);
                end
                coc_pkg::REG_CTRL2: d.ctrl2 = reg_wdata_i & coc_pkg::CTRL2_WMASK;
                coc_pkg::REG_PRI:   d.pri   = reg_wdata_i;
                coc_pkg::REG_SEC:   d.sec   = reg_wdata_i;
                default:            d.rdata = '0;
            endcase
        end

        // hardware set of the trigger flag wins over a software clear
        if (running && trig_sel && src_evt_w)
            d.ctrl2[coc_pkg::C2_TSTAT] = 1'b1;

        // channel timer
        if (!running)
            d.timer = '0;
        else if (trig_sel && !q.ctrl2[coc_pkg::C2_TSTAT])
            d.timer = '0;
        else if (!trig_sel && src_evt_w)
        begin
            d.timer      = '0;
            period_start = 1'b1;
        end
        else if (tick)
        begin
            if (match_sec)
            begin
                d.timer      = '0;
                period_start = 1'b1;
            end
            else
                d.timer = q.timer + 16'h0001;
        end

        d.carry    = period_end;
        // a channel being switched off pulses its trigger-out once
        d.trig_out = period_end || (running && d.mode == coc_pkg::MODE_OFF);

        // compare logic, only on a timer step
        if (running && tick && !(trig_sel && !q.ctrl2[coc_pkg::C2_TSTAT]))
        begin
            case (q.mode)
                coc_pkg::MODE_SS_HIGH: if (match_pri) d.pwm = 1'b1;
                coc_pkg::MODE_SS_LOW:  if (match_pri) d.pwm = 1'b0;
                coc_pkg::MODE_TOGGLE:  if (match_pri) d.pwm = !q.pwm;
                coc_pkg::MODE_EDGE:
                begin
                    if (match_pri)
                        d.pwm = 1'b0;
                    else if (q.timer == 16'h0000)
                        d.pwm = 1'b1;
                end
                coc_pkg::MODE_DBL_SS,
                coc_pkg::MODE_DBL_CON,
                coc_pkg::MODE_CENTER:
                begin
                    if (match_pri)
                        d.pwm = 1'b1;
                    else if (match_sec)
                        d.pwm = 1'b0;
                end
                default: d.pwm = 1'b0;
            endcase
        end
        else if (!running)
            d.pwm = 1'b0;

        // fault handling; the hardware set of the flag wins over the clear
        fault_hit = fault_i && q.fault_en;
        if (fault_hit)
            d.fault_flag = 1'b1;
        fault_free = !q.ctrl2[coc_pkg::C2_LATCH] || !q.fault_flag;
        if (fault_hit)
            d.fault_act = 1'b1;
        else if (q.fault_act && period_start && fault_free)
            d.fault_act = 1'b0;

        // pin: fault overrides the inverted compare level
        if (q.fault_act)
            d.oc = q.ctrl2[coc_pkg::C2_FLVL];
        else
            d.oc = q.pwm ^ q.ctrl2[coc_pkg::C2_INV];
        d.oe = !(q.ctrl2[coc_pkg::C2_PTRI] || (q.fault_act && q.ctrl2[coc_pkg::C2_FTRI]));

        // register reads
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                coc_pkg::REG_CTRL1: d.rdata = {11'h000, q.fault_flag, q.fault_en, q.mode};
                coc_pkg::REG_CTRL2: d.rdata = q.ctrl2;
                coc_pkg::REG_PRI:   d.rdata = q.pri;
                coc_pkg::REG_SEC:   d.rdata = q.sec;
                coc_pkg::REG_TMR:   d.rdata = q.timer;
                default:            d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_b_i)
        begin
            q       <= '0;
            q.ctrl2 <= coc_pkg::CTRL2_RST;
            q.oe    <= 1'b1;
        end
        else
            q <= d;
    end

    assign reg_rdata_o = q.rdata;
    assign oc_o        = q.oc;
    assign oc_oe_o     = q.oe;
    assign trig_out_o  = q.trig_out;
    assign carry_o     = q.carry;

    // checks
    a_fault_level:
    assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        q.fault_act ##1 1'b1 |-> oc_o == $past(q.ctrl2[coc_pkg::C2_FLVL]))
        else $error("fault level not driven");

    a_fault_float:
    assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        q.fault_act && q.ctrl2[coc_pkg::C2_FTRI] |=> !oc_oe_o)
        else $error("pin not floated on fault");

    a_pin_float:
    assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        q.ctrl2[coc_pkg::C2_PTRI] |=> !oc_oe_o)
        else $error("pin not floated");

    a_invert_path:
    assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        !q.fault_act && !q.ctrl2[coc_pkg::C2_PTRI] |=> oc_oe_o && oc_o == ($past(q.pwm) ^ $past(q.ctrl2[coc_pkg::C2_INV])))
        else $error("compare level or inversion wrong");

    a_trig_hold:
    assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        q.ctrl2[coc_pkg::C2_TRIG] && !q.ctrl2[coc_pkg::C2_TSTAT] |=> q.timer == 16'h0000)
        else $error("timer ran before trigger");

    a_trig_set:
    assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        q.mode != coc_pkg::MODE_OFF && q.ctrl2[coc_pkg::C2_TRIG] && src_evt_w |=> q.ctrl2[coc_pkg::C2_TSTAT])
        else $error("trigger flag not set");

    a_off_pulse:
    assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        $past(q.mode) != coc_pkg::MODE_OFF && q.mode == coc_pkg::MODE_OFF |-> trig_out_o)
        else $error("no trigger-out on switch off");

    a_edge_rise:
    assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        q.mode == coc_pkg::MODE_EDGE && !q.ctrl2[coc_pkg::C2_CASC] && !q.ctrl2[coc_pkg::C2_TRIG]
        && q.timer == 16'h0000 && q.pri != 16'h0000 && !reg_wr_i |=> q.pwm)
        else $error("edge pwm did not rise at zero");

    a_latch_hold:
    assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        q.fault_act && q.ctrl2[coc_pkg::C2_LATCH] && q.fault_flag |=> q.fault_act)
        else $error("latched fault released with flag set");

    a_none_src:
    assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        q.ctrl2[coc_pkg::C2_SEL_LSB +: coc_pkg::SEL_W] == coc_pkg::SRC_NONE_LO |-> !src_evt_w)
        else $error("event with no source selected");

    a_cascade_hold:
    assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        q.ctrl2[coc_pkg::C2_CASC] && !cascade_carry_i && !src_evt_w
        |=> q.timer == $past(q.timer) || q.timer == 16'h0000)
        else $error("cascaded timer stepped without carry");

    c_trig_run:
    cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
        !q.ctrl2[coc_pkg::C2_TSTAT] ##1 q.ctrl2[coc_pkg::C2_TSTAT] && q.ctrl2[coc_pkg::C2_TRIG]);

    c_fault_exit:
    cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
        q.fault_act ##1 !q.fault_act);

    c_switch_off:
    cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
        q.mode != coc_pkg::MODE_OFF ##1 q.mode == coc_pkg::MODE_OFF);

    c_edge_cycle:
    cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
        q.mode == coc_pkg::MODE_EDGE && !q.pwm ##1 q.pwm);

endmodule : coc_channel

// ### sim/coc_src_model.sv
// coc_src_model: on-chip event sources and the lower cascade partner.
// assumes one event per fire_i pulse, named by its select code.
module coc_src_model (
    // control
    input  wire logic       clk_i,
    input  wire logic       fire_i,
    input  wire logic [4:0] code_i,
    input  wire logic       carry_en_i,
    // sources
    output logic      [3:0] oc_trig_o = 4'h0,
    output logic      [3:0] seq_o     = 4'h0,
    output logic      [4:0] timer_o   = 5'h00,
    output logic      [3:0] capture_o = 4'h0,
    output logic      [2:0] cmp_o     = 3'h0,
    output logic            adc_o     = 1'b0,
    output logic            charge_time_unit_o    = 1'b0,
    output logic      [1:0] irq_o     = 2'h0,
    output logic            carry_o   = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [31:0] ev;

    // reserved and empty codes raise nothing
    assign ev = fire_i ? (32'h1 << code_i) : 32'h0;

    always @(posedge clk_i)
    begin
        oc_trig_o <= ev[4:1];
        seq_o     <= {4{ev[10]}};
        timer_o   <= ev[15:11];
        capture_o <= ev[19:16];
        cmp_o     <= ev[26:24];
        adc_o     <= ev[27];
        charge_time_unit_o    <= ev[28];
        irq_o     <= ev[30:29];
        // lower channel with a one-cycle period wraps every cycle
        carry_o   <= carry_en_i;
    end
endmodule : coc_src_model

// ### sim/coc_channel_tb_top.sv
// coc_channel_tb_top: self-checking bench for one compare channel.
// assumes the source model above and the register port of the channel.
module coc_channel_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [2:0]  addr = 3'h0;
    logic [15:0] wdat = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        flt = 1'b0;
    logic        fire = 1'b0;
    logic        cen = 1'b0;
    logic [4:0]  code = 5'h00;
    logic [3:0]  oct, seq, cap;
    logic [4:0]  tmr;
    logic [2:0]  cmp;
    logic [1:0]  irq;
    logic        adc, charge_time_unit, cin, oc, oe, tro, cyo;
    logic [15:0] rdat, v, r, hi, oen, cy, to;
    int          err_count = 0;
    int          n_checks = 0;

    always #12.5 clk = ~clk;

    coc_channel #(.CH_IDX(0)) dut_u (
        .core_clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_wdata_i(wdat),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .fault_i(flt),
        .cascade_carry_i(cin), .oc_trig_i(oct), .seq_i(seq), .timer_i(tmr),
        .capture_i(cap), .cmp_i(cmp), .adc_i(adc), .charge_time_unit_i(charge_time_unit), .irq_i(irq),
        .oc_o(oc), .oc_oe_o(oe), .trig_out_o(tro), .carry_o(cyo)
    );

    coc_src_model src_u (
        .clk_i(clk), .fire_i(fire), .code_i(code), .carry_en_i(cen),
        .oc_trig_o(oct), .seq_o(seq), .timer_o(tmr), .capture_o(cap), .cmp_o(cmp),
        .adc_o(adc), .charge_time_unit_o(charge_time_unit), .irq_o(irq), .carry_o(cin)
    );

    task results;
        if (err_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr   <= 1'b1;
        @(posedge clk);
        wr   <= 1'b0;
    endtask : wr_reg

    task rd_reg(input logic [2:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 v = rdat;
    endtask : rd_reg

    task fire_src(input logic [4:0] c);
        @(posedge clk);
        code <= c;
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
    endtask : fire_src

    task idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    // counts pin, enable and event pulses over n whole cycles
    task run(input int n);
        hi = 16'h0000;
        oen = 16'h0000;
        cy = 16'h0000;
        to = 16'h0000;
        repeat (n)
        begin
            #1 hi = hi + oc;
            oen = oen + oe;
            cy = cy + cyo;
            to = to + tro;
            @(posedge clk);
        end
    endtask : run

    function automatic logic [15:0] src_ok(input int c);
        return {15'h0, (c >= 1 && c <= 4) || (c >= 10 && c <= 19) || (c >= 24 && c <= 30)};
    endfunction : src_ok

    // edge pwm over two periods of eight: high from zero up to primary
    function automatic logic [15:0] pwm_hi(input logic [15:0] p, input logic inv);
        return inv ? 16'h0010 - 2 * p : 2 * p;
    endfunction : pwm_hi

    // compare level high count over two periods, primary 3 and secondary 7
    function automatic logic [15:0] mode_hi(input int m);
        case (m)
            1: return 16'h0010;
            3, 4, 5, 7: return 16'h0008;
            6: return 16'h0006;
            default: return 16'h0000;
        endcase
    endfunction : mode_hi

    initial
    begin
        void'($urandom(63));
        idle(8);
        rst_b <= 1'b1;
        rd_reg(3'h1);
        chk("ctrl2 reset", v, 16'h000c);
        rd_reg(3'h5);
        chk("unmapped", v, 16'h0000);
        r = 16'($urandom);
        wr_reg(3'h1, r);
        rd_reg(3'h1);
        chk("ctrl2 rw", v, r & 16'hf1ff);
        chk("pin tristate", {15'h0, oe}, {15'h0, ~r[5]});
        wr_reg(3'h4, r);
        rd_reg(3'h4);
        chk("timer write", v, 16'h0000);
        wr_reg(3'h1, 16'h0000);
        wr_reg(3'h3, 16'hffff);
        wr_reg(3'h0, 16'h0006);
        for (int c = 0; c < 32; c++)
        begin
            if (c == 1) continue;
            wr_reg(3'h1, 16'h0080 | 16'(c));
            fire_src(5'(c ^ 1));
            idle(2);
            rd_reg(3'h1);
            chk("decoy flag", {15'h0, v[6]}, 16'h0000);
            fire_src(5'(c));
            idle(2);
            rd_reg(3'h1);
            chk("trigger flag", {15'h0, v[6]}, src_ok(c));
        end
        wr_reg(3'h1, 16'h0080);
        idle(6);
        rd_reg(3'h4);
        chk("held timer", v, 16'h0000);
        wr_reg(3'h1, 16'h008c);
        fire_src(5'h0c);
        idle(4);
        rd_reg(3'h4);
        chk("timer runs", {15'h0, v != 16'h0000}, 16'h0001);
        wr_reg(3'h1, 16'h0000);
        wr_reg(3'h0, 16'h0000);
        run(4);
        chk("switch off", to, 16'h0001);
        wr_reg(3'h1, 16'h000c);
        wr_reg(3'h0, 16'h0006);
        idle(20);
        fire_src(5'h0c);
        rd_reg(3'h4);
        chk("sync restart", {15'h0, v < 16'h0004}, 16'h0001);
        wr_reg(3'h0, 16'h0000);
        for (int i = 0; i < 4; i++)
        begin
            v = 16'(1 + $urandom_range(5));
            r = 16'($urandom_range(1));
            wr_reg(3'h2, v);
            wr_reg(3'h3, 16'h0007);
            wr_reg(3'h1, r << 12);
            wr_reg(3'h0, 16'h0006);
            idle(16);
            run(16);
            chk("pwm high", hi, pwm_hi(v, r[0]));
            chk("pin driven", oen, 16'h0010);
            chk("wraps", cy, 16'h0002);
            wr_reg(3'h0, 16'h0000);
        end
        wr_reg(3'h2, 16'h0001);
        wr_reg(3'h3, 16'h0001);
        wr_reg(3'h1, 16'h0100);
        wr_reg(3'h0, 16'h0006);
        idle(4);
        run(16);
        chk("cascade idle", cy, 16'h0000);
        cen <= 1'b1;
        idle(4);
        run(16);
        chk("cascade carry", cy, 16'h0008);
        cen <= 1'b0;
        wr_reg(3'h0, 16'h0000);
        wr_reg(3'h2, 16'h0003);
        wr_reg(3'h3, 16'h0007);
        wr_reg(3'h1, 16'hc000);
        wr_reg(3'h0, 16'h000e);
        idle(16);
        flt <= 1'b1;
        idle(4);
        run(8);
        chk("fault high", hi, 16'h0008);
        wr_reg(3'h1, 16'he000);
        idle(2);
        run(4);
        chk("fault float", oen, 16'h0000);
        wr_reg(3'h1, 16'hc000);
        flt <= 1'b0;
        idle(16);
        run(16);
        chk("fault latched", hi, 16'h0010);
        wr_reg(3'h0, 16'h000e);
        idle(16);
        run(16);
        chk("latch released", hi, 16'h0006);
        wr_reg(3'h1, 16'h0000);
        flt <= 1'b1;
        idle(4);
        run(8);
        chk("fault low", hi, 16'h0000);
        flt <= 1'b0;
        idle(16);
        run(16);
        chk("fault released", hi, 16'h0006);
        for (int m = 0; m < 8; m++)
        begin
            wr_reg(3'h0, 16'(m));
            idle(16);
            run(16);
            chk("mode level", hi, mode_hi(m));
        end
        results();
    end

    initial
    begin
        idle(6000);
        err_count++;
        results();
    end
endmodule : coc_channel_tb_top
